// ===== verilog/ecso_cfg.svh
// constants for the checksum offload engines
// assumes byte-wide streams and positions counted from the frame's first byte
`ifndef ECSO_CFG_SVH
`define ECSO_CFG_SVH

// receive framing, positions are 14-bit byte indices
`define ECSO_HDR_LEN       14'h000e
`define ECSO_FCS_LEN       14'h0004
`define ECSO_TYPE_END      14'h000d
`define ECSO_VLAN_STEP     14'h0004
`define ECSO_SNAP_LEN      14'h0008
`define ECSO_ONE           14'h0001
`define ECSO_APPEND_LEN    14'h0002
`define ECSO_MAX_TAGS      2'h2
`define ECSO_TYPE_MIN      16'h0600

// transmit command and preamble fields
`define ECSO_CMDB_SUM_REQ  14
`define ECSO_CMDA_FIRST    13
`define ECSO_PRE_START_MSB 11
`define ECSO_PRE_START_LSB 0
`define ECSO_PRE_INS_MSB   27
`define ECSO_PRE_INS_LSB   16
`define ECSO_PRE_LAST_BYTE 2'h3
`define ECSO_TX_BUF_DEPTH  4096
`define ECSO_TX_PTR_ONE    12'h001

`endif

// ===== verilog/ecso_pkg.sv
// types and shared arithmetic of the checksum offload engines
// assumes every user imports the whole package
package ecso_pkg;

  typedef enum logic [2:0] {
    RX_FLOW   = 3'h1,
    RX_SUM_LO = 3'h2,
    RX_SUM_HI = 3'h4
  } ecso_rx_state_type;

  typedef enum logic [4:0] {
    TX_IDLE     = 5'h01,
    TX_PREAMBLE = 5'h02,
    TX_LOAD     = 5'h04,
    TX_SEND     = 5'h08,
    TX_PASS     = 5'h10
  } ecso_tx_state_type;

  // ones-complement add: the carry out goes back into the low bit
  function automatic logic [15:0] ecso_ones_add(input logic [15:0] a,
                                                input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : ecso_ones_add

endpackage : ecso_pkg

// ===== verilog/ecso_sum_if.sv
// byte feed into a sum accumulator and its running total
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface ecso_sum_if;
  logic        clear;
  logic        feed;
  logic [7:0]  data;
  logic [15:0] total;

  modport acc  (input clear, input feed, input data, output total);
  modport user (output clear, output feed, output data, input total);
endinterface : ecso_sum_if

// ===== verilog/ecso_sum_acc.sv
// pairs bytes into words and keeps the ones-complement sum
// assumes the first fed byte after clear is the low octet of word zero
`timescale 1ns/1ps
module ecso_sum_acc
  import ecso_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  ecso_sum_if.acc  sumPort
);

  logic [15:0] acc;
  logic [7:0]  held;
  logic        haveHeld;

  always_ff @(posedge mclk) begin
    if (sys_rst || sumPort.clear) begin
      acc      <= 16'h0000;
      held     <= 8'h00;
      haveHeld <= 1'b0;
    end else if (sumPort.feed) begin
      if (haveHeld) begin
        acc      <= ecso_ones_add(acc, {sumPort.data, held});
        haveHeld <= 1'b0;
      end else begin
        held     <= sumPort.data;
        haveHeld <= 1'b1;
      end
    end
  end

  // an odd byte left over pairs with a zero high octet
  assign sumPort.total = haveHeld ? ecso_ones_add(acc, {8'h00, held})
                                  : acc;

endmodule : ecso_sum_acc

// ===== verilog/ecso_offload.sv
// receive and transmit checksum offload engines of the MAC data path
// assumes byte streams from the MAC and the data FIFOs on the mclk domain
`timescale 1ns/1ps
`include "ecso_cfg.svh"
module ecso_offload
  import ecso_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        rxSumEnable,
  input  wire logic        rxSumModeSelect,
  input  wire logic [15:0] vlanTagTypeValue,
  input  wire logic        txSumEnable,
  input  wire logic        rxInValid,
  input  wire logic [7:0]  rxInData,
  input  wire logic        rxInLast,
  output wire logic        rxInReady,
  output logic             rxOutValid,
  output logic [7:0]       rxOutData,
  output logic             rxOutLast,
  output logic [13:0]      rxLength,
  output logic             rxLengthValid,
  input  wire logic        txCmdValid,
  input  wire logic [31:0] txCmdA,
  input  wire logic [31:0] txCmdB,
  output wire logic        txCmdReady,
  input  wire logic        txInValid,
  input  wire logic [7:0]  txInData,
  input  wire logic        txInLast,
  output wire logic        txInReady,
  output logic             txOutValid,
  output logic [7:0]       txOutData,
  output logic             txOutLast,
  input  wire logic        txOutReady
);

  // ---------------------------------------------------------------
  // receive engine
  // ---------------------------------------------------------------
  ecso_sum_if rxSum ();
  ecso_sum_acc rxAcc (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .sumPort (rxSum)
  );

  ecso_rx_state_type rxState;
  ecso_rx_state_type next_rxState;
  logic [7:0]  hist [4];
  logic [13:0] rxCount;
  logic [13:0] typeEnd;
  logic [13:0] sumStart;
  logic        startKnown;
  logic [1:0]  tagCount;
  logic [7:0]  typeHi;

  wire         rxAccept  = rxInValid && rxInReady;
  // the last four bytes sit in the history when the frame ends, so the
  // oldest entry is known to be ahead of the check sequence
  wire         candValid = rxAccept && (rxCount >= `ECSO_FCS_LEN);
  wire  [7:0]  candData  = hist[3];
  wire  [13:0] candPos   = rxCount - `ECSO_FCS_LEN;
  wire  [15:0] typeWord  = {typeHi, candData};
  wire         atTypeEnd = candValid && rxSumModeSelect
                           && !startKnown && (candPos == typeEnd);
  wire         isTag     = (typeWord == vlanTagTypeValue)
                           && (tagCount < `ECSO_MAX_TAGS);
  wire         isLength  = typeWord < `ECSO_TYPE_MIN;
  wire         inRange0  = candPos >= `ECSO_HDR_LEN;
  wire         inRange1  = startKnown && (candPos >= sumStart);
  wire         frameEnd  = rxAccept && rxInLast;

  assign rxInReady   = (rxState == RX_FLOW);
  assign rxSum.clear = rxAccept && (rxCount == 14'h0000);
  assign rxSum.feed  = candValid && rxSumEnable
                       && (rxSumModeSelect ? inRange1 : inRange0);
  assign rxSum.data  = candData;

  always_comb begin
    next_rxState = rxState;
    case (rxState)
      RX_FLOW: begin
        if (frameEnd && rxSumEnable) begin
          next_rxState = RX_SUM_LO;
        end
      end
      RX_SUM_LO: begin
        next_rxState = RX_SUM_HI;
      end
      RX_SUM_HI: begin
        next_rxState = RX_FLOW;
      end
      default: begin
        next_rxState = RX_FLOW;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxState <= RX_FLOW;
    end else begin
      rxState <= next_rxState;
    end
  end

  // history and byte count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hist    <= '{default: 8'h00};
      rxCount <= 14'h0000;
    end else if (rxAccept) begin
      hist    <= '{rxInData, hist[0], hist[1], hist[2]};
      rxCount <= rxInLast ? 14'h0000 : rxCount + `ECSO_ONE;
    end
  end

  // ---------------------------------------------------------------
  // layer-3 start search for mode one
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || frameEnd) begin
      typeEnd    <= `ECSO_TYPE_END;
      sumStart   <= 14'h0000;
      startKnown <= 1'b0;
      tagCount   <= 2'h0;
      typeHi     <= 8'h00;
    end else begin
      if (candValid && (candPos == typeEnd - `ECSO_ONE)) begin
        typeHi <= candData;
      end
      if (atTypeEnd) begin
        if (isTag) begin
          tagCount <= tagCount + 2'h1;
          typeEnd  <= typeEnd + `ECSO_VLAN_STEP;
        end else if (isLength) begin
          // a length field means LLC and SNAP precede the packet
          sumStart   <= typeEnd + `ECSO_ONE + `ECSO_SNAP_LEN;
          startKnown <= 1'b1;
        end else begin
          sumStart   <= typeEnd + `ECSO_ONE;
          startKnown <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // receive output and length
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxOutValid <= 1'b0;
      rxOutData  <= 8'h00;
      rxOutLast  <= 1'b0;
    end else if (rxState == RX_SUM_LO) begin
      rxOutValid <= 1'b1;
      rxOutData  <= rxSum.total[7:0];
      rxOutLast  <= 1'b0;
    end else if (rxState == RX_SUM_HI) begin
      rxOutValid <= 1'b1;
      rxOutData  <= rxSum.total[15:8];
      rxOutLast  <= 1'b1;
    end else begin
      rxOutValid <= rxAccept;
      rxOutData  <= rxInData;
      rxOutLast  <= rxInLast && !rxSumEnable;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxLength      <= 14'h0000;
      rxLengthValid <= 1'b0;
    end else begin
      rxLengthValid <= frameEnd;
      if (frameEnd) begin
        rxLength <= rxCount + `ECSO_ONE
                    + (rxSumEnable ? `ECSO_APPEND_LEN : 14'h0000);
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit engine
  // ---------------------------------------------------------------
  ecso_sum_if txSum ();
  ecso_sum_acc txAcc (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .sumPort (txSum)
  );

  ecso_tx_state_type txState;
  ecso_tx_state_type next_txState;
  // whole packet is held because the insert point may precede the
  // summed range; longer packets wrap and are corrupted
  logic [7:0]  txBuf [`ECSO_TX_BUF_DEPTH];
  logic [31:0] preamble;
  logic [1:0]  preCount;
  logic [11:0] wrPtr;
  logic [11:0] rdPtr;
  logic [11:0] txLast;

  wire         sumWanted = txCmdB[`ECSO_CMDB_SUM_REQ]
                           && txCmdA[`ECSO_CMDA_FIRST]
                           && txSumEnable;
  wire  [11:0] startOff  = preamble[`ECSO_PRE_START_MSB:`ECSO_PRE_START_LSB];
  wire  [11:0] insOff    = preamble[`ECSO_PRE_INS_MSB:`ECSO_PRE_INS_LSB];
  wire         outFree   = !txOutValid || txOutReady;
  wire         txAccept  = txInValid && txInReady;
  wire         cmdTaken  = txCmdValid && txCmdReady;
  wire  [15:0] sumInv    = ~txSum.total;
  wire         insLo     = rdPtr == insOff;
  wire         insHi     = rdPtr == insOff + `ECSO_TX_PTR_ONE;
  wire  [7:0]  sendByte  = insLo ? sumInv[7:0]
                         : insHi ? sumInv[15:8] : txBuf[rdPtr];
  wire         sendStep  = (txState == TX_SEND) && outFree;

  assign txCmdReady  = (txState == TX_IDLE);
  assign txInReady   = (txState == TX_PASS) ? outFree
                     : (txState == TX_PREAMBLE) || (txState == TX_LOAD);
  assign txSum.clear = cmdTaken;
  assign txSum.feed  = txAccept && (txState == TX_LOAD)
                       && (wrPtr >= startOff);
  assign txSum.data  = txInData;

  always_comb begin
    next_txState = txState;
    case (txState)
      TX_IDLE: begin
        if (cmdTaken) begin
          next_txState = sumWanted ? TX_PREAMBLE : TX_PASS;
        end
      end
      TX_PREAMBLE: begin
        if (txAccept && txInLast) begin
          next_txState = TX_IDLE;
        end else if (txAccept && (preCount == `ECSO_PRE_LAST_BYTE)) begin
          next_txState = TX_LOAD;
        end
      end
      TX_LOAD: begin
        if (txAccept && txInLast) begin
          next_txState = TX_SEND;
        end
      end
      TX_SEND: begin
        if (sendStep && (rdPtr == txLast)) begin
          next_txState = TX_IDLE;
        end
      end
      TX_PASS: begin
        if (txAccept && txInLast) begin
          next_txState = TX_IDLE;
        end
      end
      default: begin
        next_txState = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txState <= TX_IDLE;
    end else begin
      txState <= next_txState;
    end
  end

  // preamble capture and packet store; the preamble is never forwarded
  always_ff @(posedge mclk) begin
    if (sys_rst || cmdTaken) begin
      preamble <= 32'h0000_0000;
      preCount <= 2'h0;
      wrPtr    <= 12'h000;
      txLast   <= 12'h000;
    end else if (txAccept && (txState == TX_PREAMBLE)) begin
      preamble[{preCount, 3'h0} +: 8] <= txInData;
      preCount <= preCount + 2'h1;
    end else if (txAccept && (txState == TX_LOAD)) begin
      wrPtr <= wrPtr + `ECSO_TX_PTR_ONE;
      if (txInLast) begin
        txLast <= wrPtr;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (txAccept && (txState == TX_LOAD)) begin
      txBuf[wrPtr] <= txInData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || cmdTaken) begin
      rdPtr <= 12'h000;
    end else if (sendStep) begin
      rdPtr <= rdPtr + `ECSO_TX_PTR_ONE;
    end
  end

  // ---------------------------------------------------------------
  // transmit output register toward the MAC
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txOutValid <= 1'b0;
      txOutData  <= 8'h00;
      txOutLast  <= 1'b0;
    end else if (sendStep) begin
      txOutValid <= 1'b1;
      txOutData  <= sendByte;
      txOutLast  <= rdPtr == txLast;
    end else if (txAccept && (txState == TX_PASS)) begin
      txOutValid <= 1'b1;
      txOutData  <= txInData;
      txOutLast  <= txInLast;
    end else if (txOutReady) begin
      txOutValid <= 1'b0;
      txOutLast  <= 1'b0;
    end
  end

endmodule : ecso_offload

// ===== testbench/ecso_offload_assertions.sv
// timing checks on the checksum offload top ports
// assumes it is bound to every ecso_offload instance
`timescale 1ns/1ps
module ecso_offload_assertions (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        rxSumEnable,
  input wire logic        rxInValid,
  input wire logic [7:0]  rxInData,
  input wire logic        rxInLast,
  input wire logic        rxInReady,
  input wire logic        rxOutValid,
  input wire logic [7:0]  rxOutData,
  input wire logic        rxOutLast,
  input wire logic [13:0] rxLength,
  input wire logic        rxLengthValid,
  input wire logic        txCmdValid,
  input wire logic        txCmdReady,
  input wire logic        txOutValid,
  input wire logic [7:0]  txOutData,
  input wire logic        txOutLast,
  input wire logic        txOutReady
);
  // ----------------------------------------
  // frame byte count
  // ----------------------------------------
  logic [13:0] byteCount;
  wire         rxTake = rxInValid && rxInReady;
  wire         rxEnd  = rxTake && rxInLast;

  always_ff @(posedge mclk)
    if (sys_rst)
      byteCount <= 14'h0000;
    else if (rxTake)
      byteCount <= rxInLast ? 14'h0000 : byteCount + 14'h0001;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_rx_forward: assert property (
    rxTake |=> rxOutValid && rxOutData == $past(rxInData))
    else $error("received byte not forwarded one cycle later");
  chk_rx_refuse: assert property (
    rxEnd && rxSumEnable |=> !rxInReady ##1 !rxInReady ##1 rxInReady)
    else $error("input not held off for two append cycles");
  chk_rx_append_last: assert property (
    rxEnd && rxSumEnable |=> !rxOutLast ##1 !rxOutLast ##1 rxOutLast)
    else $error("frame end not moved behind the two sum bytes");
  chk_rx_length: assert property (
    rxEnd |=> rxLengthValid && rxLength == $past(byteCount)
      + ($past(rxSumEnable) ? 14'h0003 : 14'h0001))
    else $error("reported frame length wrong");
  chk_rx_no_spurious: assert property (
    rxInReady && !rxInValid |=> !rxOutValid)
    else $error("output byte without an input byte");
  chk_tx_hold: assert property (
    txOutValid && !txOutReady |=> txOutValid && $stable(txOutData)
      && $stable(txOutLast))
    else $error("transmit byte changed before it was taken");
  chk_cmd_busy: assert property (
    txCmdValid && txCmdReady |=> !txCmdReady)
    else $error("command accepted while a packet is open");
  chk_tx_end_gap: assert property (
    txOutValid && txOutReady && txOutLast |=> !txOutValid)
    else $error("transmit output continues past packet end");
endmodule : ecso_offload_assertions

bind ecso_offload ecso_offload_assertions chk (
  .mclk(mclk), .sys_rst(sys_rst), .rxSumEnable(rxSumEnable),
  .rxInValid(rxInValid), .rxInData(rxInData), .rxInLast(rxInLast),
  .rxInReady(rxInReady), .rxOutValid(rxOutValid), .rxOutData(rxOutData),
  .rxOutLast(rxOutLast), .rxLength(rxLength),
  .rxLengthValid(rxLengthValid), .txCmdValid(txCmdValid),
  .txCmdReady(txCmdReady), .txOutValid(txOutValid),
  .txOutData(txOutData), .txOutLast(txOutLast), .txOutReady(txOutReady));

// ===== testbench/ecso_mac_sink.sv
// mac model taking transmit bytes promptly or with random stalls
// assumes the bench seeds $urandom and sets slowMode between packets
`timescale 1ns/1ps
module ecso_mac_sink (
  input  wire logic mclk,
  input  wire logic slowMode,
  output logic      txOutReady
);
  initial txOutReady = 1'b1;
  // random stalls so that held bytes last for varying lengths
  always @(posedge mclk) begin
    #1;
    txOutReady = !slowMode || ($urandom % 3 == 0);
  end
endmodule : ecso_mac_sink

// ===== testbench/ethernet_checksum_offload_test.sv
// self-checking bench for the receive and transmit sum engines
// assumes ecso_mac_sink on the transmit output and the bound checker
`timescale 1ns/1ps
`define ECSO_CHECK(got, exp) begin \
  logic [15:0] cg, ce; \
  cg = got; \
  ce = exp; \
  nChecks++; \
  if (cg !== ce) begin \
    failCount++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, cg, ce); \
  end \
end
module ethernet_checksum_offload_test;
  typedef logic [7:0] ecso_bytes_type[$];
  logic        mclk, sys_rst, rxSumEnable, rxSumModeSelect, txSumEnable;
  logic        rxInValid, rxInLast, rxInReady, rxOutValid, rxOutLast;
  logic        rxLengthValid, txCmdValid, txCmdReady, txInValid, txInLast;
  logic        txInReady, txOutValid, txOutLast, txOutReady, slowMode;
  logic [7:0]  rxInData, rxOutData, txInData, txOutData;
  logic [13:0] rxLength;
  logic [15:0] vlanTagTypeValue;
  logic [31:0] txCmdA, txCmdB;
  logic [8:0]  rxQ[$], txQ[$];
  logic [13:0] lenQ[$];
  int          failCount = 0, nChecks = 0;
  int          tagN[7] = '{0, 1, 2, 3, 0, 2, 0};
  logic [15:0] tyV[7] = '{16'h0800, 16'h0800, 16'h0800, 16'h0800,
                          16'h002e, 16'h002e, 16'h8100};
  ecso_bytes_type f;

  ecso_offload dut (
    .mclk(mclk), .sys_rst(sys_rst), .rxSumEnable(rxSumEnable),
    .rxSumModeSelect(rxSumModeSelect), .vlanTagTypeValue(vlanTagTypeValue),
    .txSumEnable(txSumEnable), .rxInValid(rxInValid), .rxInData(rxInData),
    .rxInLast(rxInLast), .rxInReady(rxInReady), .rxOutValid(rxOutValid),
    .rxOutData(rxOutData), .rxOutLast(rxOutLast), .rxLength(rxLength),
    .rxLengthValid(rxLengthValid), .txCmdValid(txCmdValid),
    .txCmdA(txCmdA), .txCmdB(txCmdB), .txCmdReady(txCmdReady),
    .txInValid(txInValid), .txInData(txInData), .txInLast(txInLast),
    .txInReady(txInReady), .txOutValid(txOutValid), .txOutData(txOutData),
    .txOutLast(txOutLast), .txOutReady(txOutReady));
  ecso_mac_sink mac (.mclk(mclk), .slowMode(slowMode),
                     .txOutReady(txOutReady));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic stopTest();
    if (failCount == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stopTest

  function automatic logic [8:0] pop9(ref logic [8:0] q[$]);
    return q.size() ? q.pop_front() : 'x;
  endfunction : pop9

  function automatic logic [13:0] pop14(ref logic [13:0] q[$]);
    return q.size() ? q.pop_front() : 'x;
  endfunction : pop14

  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rxOutValid === 1'b1)
      `ECSO_CHECK({rxOutLast, rxOutData}, pop9(rxQ))
    if (rxLengthValid === 1'b1)
      `ECSO_CHECK(rxLength, pop14(lenQ))
    if (txOutValid === 1'b1 && txOutReady === 1'b1)
      `ECSO_CHECK({txOutLast, txOutData}, pop9(txQ))
  end

  // ----------------------------------------
  // reference arithmetic and drivers
  // ----------------------------------------
  function automatic logic [15:0] csum(ecso_bytes_type b, int s, int e);
    logic [16:0] a;
    a = 17'h00000;
    for (int i = s; i < e; i += 2) begin
      a = a[15:0] + {(i + 1 < e) ? b[i + 1] : 8'h00, b[i]};
      a = a[15:0] + a[16];
    end
    return a[15:0];
  endfunction : csum

  function automatic ecso_bytes_type rnd(int n);
    ecso_bytes_type q;
    repeat (n) q.push_back(8'($urandom));
    return q;
  endfunction : rnd

  task automatic waitHigh(ref logic sig);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (sig !== 1'b1 && k < 1000);
    if (sig !== 1'b1) begin
      `ECSO_CHECK(sig, 1'b1)
      stopTest();
    end
    #1;
  endtask : waitHigh

  task automatic rxFrame(logic en, logic md, ecso_bytes_type b);
    int s, t, n;
    logic [15:0] sm;
    n = b.size();
    s = md ? 12 : 14;
    t = 0;
    while (md && t < 2 && {b[s], b[s + 1]} === vlanTagTypeValue) begin
      s += 4;
      t++;
    end
    if (md)
      s += ({b[s], b[s + 1]} < 16'h0600) ? 10 : 2;
    sm = csum(b, s, n - 4);
    // the previous frame has drained, so the bits may change now
    rxSumEnable = en;
    rxSumModeSelect = md;
    foreach (b[i]) rxQ.push_back({!en && i == n - 1, b[i]});
    if (en) begin
      rxQ.push_back({1'b0, sm[7:0]});
      rxQ.push_back({1'b1, sm[15:8]});
    end
    // no pad is stripped while the engine is on, so every byte comes back
    lenQ.push_back(14'(en ? n + 2 : n));
    foreach (b[i]) begin
      rxInValid = 1'b1;
      rxInData = b[i];
      rxInLast = (i == n - 1);
      waitHigh(rxInReady);
    end
    rxInValid = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : rxFrame

  task automatic txByte(logic [7:0] d, logic l);
    txInValid = 1'b1;
    txInData = d;
    txInLast = l;
    waitHigh(txInReady);
  endtask : txByte

  task automatic txPacket(logic fs, logic ck, logic [11:0] st,
                          logic [11:0] ins, ecso_bytes_type p);
    logic off;
    logic [31:0] pre;
    logic [15:0] sm;
    ecso_bytes_type q;
    int w;
    // a new command only once the previous packet has left the output
    w = 0;
    while (txQ.size() > 0 && w < 1000) begin
      @(posedge mclk);
      #1;
      w++;
    end
    if (txQ.size() > 0) begin
      `ECSO_CHECK(txQ.size(), 0)
      stopTest();
    end
    off = fs && ck && txSumEnable;
    pre = {4'h0, ins, 4'h0, st};
    q = p;
    if (off) begin
      sm = ~csum(p, st, p.size());
      q[ins] = sm[7:0];
      q[ins + 1] = sm[15:8];
    end
    foreach (q[i]) txQ.push_back({i == q.size() - 1, q[i]});
    txCmdValid = 1'b1;
    txCmdA = {18'h00000, fs, 13'h0000};
    txCmdB = {17'h00000, ck, 3'h0, 11'(p.size() + (off ? 4 : 0))};
    waitHigh(txCmdReady);
    txCmdValid = 1'b0;
    if (off)
      for (int k = 0; k < 4; k++) txByte(pre[8 * k +: 8], 1'b0);
    foreach (p[i]) txByte(p[i], i == p.size() - 1);
    txInValid = 1'b0;
  endtask : txPacket

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sys_rst, rxSumEnable, rxSumModeSelect, txSumEnable} = 4'h8;
    {rxInValid, rxInLast, txCmdValid, txInValid, txInLast} = 5'h00;
    {rxInData, txInData, txCmdA, txCmdB} = 80'h0;
    vlanTagTypeValue = 16'h8100;
    slowMode = 1'b0;
    void'($urandom(54));
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    rxFrame(1'b1, 1'b0, rnd(61));
    rxFrame(1'b1, 1'b0, rnd(64));
    rxFrame(1'b0, 1'b1, rnd(60));
    for (int v = 0; v < 2; v++) begin
      vlanTagTypeValue = v ? 16'h88a8 : 16'h8100;
      for (int k = 0; k < 7; k++) begin
        f = rnd(12);
        repeat (tagN[k]) f = {f, vlanTagTypeValue[15:8],
                              vlanTagTypeValue[7:0], rnd(2)};
        f = {f, tyV[k][15:8], tyV[k][7:0], rnd(41 + k)};
        rxFrame(1'b1, 1'b1, f);
      end
    end
    txSumEnable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      slowMode = k[0];
      // offsets stay clear of the header and the last four bytes
      txPacket(1'b1, 1'b1, 12'(14 + $urandom % 30),
               12'(14 + $urandom % 40), rnd(63 + k));
    end
    f = {};
    repeat (30) f.push_back(8'h00);
    f[20] = 8'hff;
    f[21] = 8'hff;
    txPacket(1'b1, 1'b1, 12'h00e, 12'h010, f);
    txPacket(1'b1, 1'b0, 12'h000, 12'h000, rnd(40));
    txPacket(1'b0, 1'b1, 12'h000, 12'h000, rnd(41));
    waitHigh(txCmdReady);
    txSumEnable = 1'b0;
    txPacket(1'b1, 1'b1, 12'h000, 12'h000, rnd(42));
    for (int k = 0; k < 2000 && txQ.size() + rxQ.size() > 0; k++)
      @(posedge mclk);
    `ECSO_CHECK(txQ.size() + rxQ.size() + lenQ.size(), 0)
    stopTest();
  end
endmodule : ethernet_checksum_offload_test
